/* hw/rgm_cmd_core.sv */
/*
  rgm_cmd_core: direct command execution for receive masking, amplitude
  measurement, squelch, receive gain reset and regulator adjustment,
  plus the receiver configuration bits, behind a Wishbone slave.
  Assumes the converter, detectors, regulator and mask timer sit outside
  on the same clock, except xtal_stable_i and margin_ok_i, which are
  analog levels and are synchronised here.
*/
// The Wishbone slave port was decided locally.
// Operation
// - mask command drives receive gate low and stops receive framing
// - effective mask is command mask OR mask timer state
// - unmask raises gate, enables framing, resets running mask timer
// - mask and unmask only accepted while receiver enable is set
// - mask, unmask, gain reset chain; measure, squelch, regulator do not
// - termination pulse after measure amplitude and regulator adjust only
// - measure enables transmitter, detector, absolute converter, stores result
// - amplitude code is 13.02 mV pp per lsb, full scale E6h
// - measure amplitude finishes within 25 us
// - measure, gain reset, regulator need enable bit and stable crystal
// - squelch needs tx and rx on, runs only with gate low, 500 us
// - gain reset inits agc, aborts squelch, loads manual gain
// - regulator adjust switches rx and tx on, regulator to maximum
// - every 300 us lower regulator one step if margin below 250 mV
// - stepping stops at margin reached or minimum setting
// - regulator adjust finishes within 5 ms
// - regulator adjust refused while external regulator select is set
// - config three holds clip and active mode gain reduce bits
// - filter bits 4:3 low pass, bits 2:0 zero setting
`timescale 1ns/1ps
module rgm_cmd_core import rgm_pkg::*; #(
  parameter int SQUELCH_CYCLES = SQUELCH_CYC,
  parameter int REG_PERIOD_CYCLES = REG_PERIOD_CYC,
  parameter int ADJ_REG_CYCLES = ADJ_REG_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic xtal_stable_i,
  input wire logic margin_ok_i,
  input wire logic mask_timer_run_i,
  input wire logic adc_valid_i,
  input wire logic [7:0] adc_data_i,
  output logic rx_on_o,
  output logic framing_en_o,
  output logic mask_timer_reset_o,
  output logic tx_force_on_o,
  output logic rx_force_on_o,
  output logic amp_det_en_o,
  output logic adc_abs_mode_o,
  output logic squelch_active_o,
  output logic agc_init_o,
  output logic [7:0] manual_gain_o,
  output logic [3:0] reg_step_o,
  output logic cmd_term_o,
  output logic busy_o,
  output rgm_cfg3_t cfg3_o,
  output rgm_filt_t filt_o
);

  localparam logic [19:0] MEAS_LIMIT = 20'(MEAS_AMP_CYC - 1);
  localparam logic [19:0] SQL_LIMIT = 20'(SQUELCH_CYCLES - 1);
  localparam logic [19:0] PERIOD_LIMIT = 20'(REG_PERIOD_CYCLES - 1);
  localparam logic [19:0] ADJ_LIMIT = 20'(ADJ_REG_CYCLES - 1);

  logic [7:0] ctrl_reg;
  logic [7:0] cfg3_reg;
  logic [7:0] cfg4_reg;
  logic [7:0] filt_reg;
  logic [7:0] adc_out_reg;
  logic mask_cmd_reg;
  logic xtal_meta_reg;
  logic xtal_sync_reg;
  logic margin_meta_reg;
  logic margin_sync_reg;
  rgm_state_t state_reg;
  logic [19:0] cnt_reg;
  logic [19:0] total_reg;
  logic [3:0] step_reg;

  logic bus_req;
  logic wr_req;
  logic cmd_wr;
  logic [7:0] cmd_code;
  logic en_ok;
  logic do_mask;
  logic do_unmask;
  logic do_meas;
  logic do_squelch;
  logic do_gain_reset;
  logic do_adj;
  logic mask_cmd_next;
  logic mask_any;

  // bus slave: one wait state, ack drops after one cycle
  assign bus_req = cyc_i & stb_i & ~ack_o;
  assign wr_req = bus_req & we_i;
  assign cmd_wr = wr_req & (adr_i == OFS_CMD) & sel_i[0];
  assign cmd_code = dat_i[7:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (bus_req & ~we_i) begin
      case (adr_i)
        OFS_CTRL: dat_o <= {24'h000000, ctrl_reg};
        OFS_STATUS: dat_o <= {24'h000000, step_reg, squelch_active_o, mask_cmd_reg, rx_on_o,
                              busy_o};
        OFS_RX_CFG3: dat_o <= {24'h000000, cfg3_reg};
        OFS_RX_CFG4: dat_o <= {24'h000000, cfg4_reg};
        OFS_ADC_OUT: dat_o <= {24'h000000, adc_out_reg};
        OFS_RX_FILT: dat_o <= {24'h000000, filt_reg};
        default: dat_o <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RESET;
      cfg3_reg <= CFG3_RESET;
      cfg4_reg <= CFG4_RESET;
      filt_reg <= FILT_RESET;
    end else if (wr_req & sel_i[0]) begin
      case (adr_i)
        OFS_CTRL: ctrl_reg <= dat_i[7:0];
        OFS_RX_CFG3: cfg3_reg <= {6'h00, dat_i[1:0]};
        OFS_RX_CFG4: cfg4_reg <= dat_i[7:0];
        OFS_RX_FILT: filt_reg <= {3'h0, dat_i[4:0]};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg3_o <= '0;
      filt_o <= '0;
    end else begin
      cfg3_o <= rgm_cfg3_t'(cfg3_reg[1:0]);
      filt_o <= rgm_filt_t'(filt_reg[4:0]);
    end
  end

  // analog levels, two flops before use
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xtal_meta_reg <= 1'b0;
      xtal_sync_reg <= 1'b0;
      margin_meta_reg <= 1'b0;
      margin_sync_reg <= 1'b0;
    end else begin
      xtal_meta_reg <= xtal_stable_i;
      xtal_sync_reg <= xtal_meta_reg;
      margin_meta_reg <= margin_ok_i;
      margin_sync_reg <= margin_meta_reg;
    end
  end

  // command acceptance; refused codes leave everything as it was
  assign en_ok = ctrl_reg[CTRL_EN_BIT] & xtal_sync_reg;
  assign do_mask = cmd_wr & (cmd_code == CMD_MASK_RX) & ctrl_reg[CTRL_RX_EN_BIT];
  assign do_unmask = cmd_wr & (cmd_code == CMD_UNMASK_RX) & ctrl_reg[CTRL_RX_EN_BIT];
  // chainable ones are taken even while a squelch runs
  assign do_gain_reset = cmd_wr & (cmd_code == CMD_RESET_GAIN) & en_ok;
  // non-chainable ones need a free engine
  assign do_meas = cmd_wr & (cmd_code == CMD_MEAS_AMP) & en_ok & ~busy_o;
  assign do_adj = cmd_wr & (cmd_code == CMD_ADJ_REG) & en_ok & ~busy_o
                  & ~ctrl_reg[CTRL_EXT_REG_BIT];
  // squelch with gate high is refused, as it would have nothing to do
  assign do_squelch = cmd_wr & (cmd_code == CMD_SQUELCH) & ~busy_o
                      & ctrl_reg[CTRL_TX_EN_BIT] & ctrl_reg[CTRL_RX_EN_BIT]
                      & ~rx_on_o;

  always_comb begin
    mask_cmd_next = mask_cmd_reg;
    if (do_mask) begin
      mask_cmd_next = 1'b1;
    end else if (do_unmask) begin
      mask_cmd_next = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_cmd_reg <= 1'b0;
    end else begin
      mask_cmd_reg <= mask_cmd_next;
    end
  end

  // gate is the or of both mask sources; unmask also overrides the timer
  assign mask_any = mask_cmd_next | (mask_timer_run_i & ~do_unmask);
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_on_o <= 1'b0;
      framing_en_o <= 1'b0;
      mask_timer_reset_o <= 1'b0;
    end else begin
      rx_on_o <= ctrl_reg[CTRL_RX_EN_BIT] & ~mask_any;
      framing_en_o <= ~mask_any;
      mask_timer_reset_o <= do_unmask & mask_timer_run_i;
    end
  end

  // gain reset: one-cycle init pulse and manual gain load
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      agc_init_o <= 1'b0;
      manual_gain_o <= 8'h00;
    end else begin
      agc_init_o <= do_gain_reset;
      if (do_gain_reset) begin
        manual_gain_o <= cfg4_reg;
      end
    end
  end

  // sequence engine for the non-chainable commands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 20'h00000;
      total_reg <= 20'h00000;
      step_reg <= REG_TOP_STEP;
      busy_o <= 1'b0;
      cmd_term_o <= 1'b0;
      adc_out_reg <= 8'h00;
      tx_force_on_o <= 1'b0;
      rx_force_on_o <= 1'b0;
      amp_det_en_o <= 1'b0;
      adc_abs_mode_o <= 1'b0;
      squelch_active_o <= 1'b0;
    end else begin
      cmd_term_o <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          cnt_reg <= 20'h00000;
          total_reg <= 20'h00000;
          if (do_meas) begin
            state_reg <= ST_MEAS_AMP;
            busy_o <= 1'b1;
            tx_force_on_o <= 1'b1;
            amp_det_en_o <= 1'b1;
            adc_abs_mode_o <= 1'b1;
          end else if (do_adj) begin
            state_reg <= ST_ADJ_REG;
            busy_o <= 1'b1;
            tx_force_on_o <= 1'b1;
            rx_force_on_o <= 1'b1;
            step_reg <= REG_TOP_STEP;
          end else if (do_squelch) begin
            state_reg <= ST_SQUELCH;
            busy_o <= 1'b1;
            squelch_active_o <= 1'b1;
          end
        end
        ST_MEAS_AMP: begin
          cnt_reg <= cnt_reg + 20'h00001;
          // result saturates at the full-scale code; timeout keeps old result
          if (adc_valid_i | (cnt_reg == MEAS_LIMIT)) begin
            if (adc_valid_i) begin
              adc_out_reg <= (adc_data_i > AMP_MAX_CODE) ? AMP_MAX_CODE : adc_data_i;
            end
            state_reg <= ST_IDLE;
            busy_o <= 1'b0;
            cmd_term_o <= 1'b1;
            tx_force_on_o <= 1'b0;
            amp_det_en_o <= 1'b0;
            adc_abs_mode_o <= 1'b0;
          end
        end
        ST_SQUELCH: begin
          cnt_reg <= cnt_reg + 20'h00001;
          // no termination pulse here, also when aborted
          if (do_gain_reset | (cnt_reg == SQL_LIMIT)) begin
            state_reg <= ST_IDLE;
            busy_o <= 1'b0;
            squelch_active_o <= 1'b0;
          end
        end
        ST_ADJ_REG: begin
          total_reg <= total_reg + 20'h00001;
          if (cnt_reg == PERIOD_LIMIT) begin
            cnt_reg <= 20'h00000;
            if (margin_sync_reg | (step_reg == 4'h0)) begin
              state_reg <= ST_IDLE;
            end else begin
              step_reg <= step_reg - 4'h1;
            end
          end else begin
            cnt_reg <= cnt_reg + 20'h00001;
          end
          // hard stop so the command never outlives its budget
          if ((total_reg == ADJ_LIMIT) | ((cnt_reg == PERIOD_LIMIT)
              & (margin_sync_reg | (step_reg == 4'h0)))) begin
            state_reg <= ST_IDLE;
            busy_o <= 1'b0;
            cmd_term_o <= 1'b1;
            tx_force_on_o <= 1'b0;
            rx_force_on_o <= 1'b0;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reg_step_o <= REG_TOP_STEP;
    end else begin
      reg_step_o <= step_reg;
    end
  end

  // supply choice only changes the mV meaning of a step, not the count
  logic supply_5v_unused;
  assign supply_5v_unused = ctrl_reg[CTRL_SUPPLY_5V_BIT];

endmodule

/* hw/rgm_pkg.sv */
/*
  rgm_pkg: shared constants and carrier types for the receive gain and
  measurement command block. Assumes a 20 MHz system clock and a
  classic Wishbone slave with 32-bit data and byte addresses.
*/
package rgm_pkg;

  localparam int CLK_HZ = 20_000_000;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RX_CFG3 = 8'h0C;
  localparam logic [7:0] OFS_RX_CFG4 = 8'h10;
  localparam logic [7:0] OFS_ADC_OUT = 8'h14;
  localparam logic [7:0] OFS_RX_FILT = 8'h18;

  // control register fields
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_RX_EN_BIT = 6;
  localparam int CTRL_TX_EN_BIT = 3;
  localparam int CTRL_EXT_REG_BIT = 2;
  localparam int CTRL_SUPPLY_5V_BIT = 0;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CFG3_RESET = 8'h00;
  localparam logic [7:0] CFG4_RESET = 8'h00;
  localparam logic [7:0] FILT_RESET = 8'h00;

  // command codes written to OFS_CMD
  localparam logic [7:0] CMD_MASK_RX = 8'hD0;
  localparam logic [7:0] CMD_UNMASK_RX = 8'hD1;
  localparam logic [7:0] CMD_MEAS_AMP = 8'hD3;
  localparam logic [7:0] CMD_SQUELCH = 8'hD4;
  localparam logic [7:0] CMD_RESET_GAIN = 8'hD5;
  localparam logic [7:0] CMD_ADJ_REG = 8'hD6;

  // amplitude code: 13.02 mV pp per lsb, full scale input gives this
  localparam logic [7:0] AMP_MAX_CODE = 8'hE6;

  // regulator: 5.1 V down to 3.9 V by 120 mV, or 3.4 V to 2.4 V by 100 mV
  localparam int REG_MAX_MV_5V = 5100;
  localparam int REG_MIN_MV_5V = 3900;
  localparam int REG_STEP_MV_5V = 120;
  localparam int REG_MAX_MV_3V = 3400;
  localparam int REG_MIN_MV_3V = 2400;
  localparam int REG_STEP_MV_3V = 100;
  localparam int REG_MARGIN_MV = 250;
  localparam logic [3:0] REG_TOP_STEP = 4'((REG_MAX_MV_5V - REG_MIN_MV_5V) / REG_STEP_MV_5V);

  // timing, longest times round down
  localparam int MEAS_AMP_US = 25;
  localparam int SQUELCH_US = 500;
  localparam int REG_PERIOD_US = 300;
  localparam int ADJ_REG_MS = 5;
  localparam int MEAS_AMP_CYC = MEAS_AMP_US * (CLK_HZ / 1_000_000);
  localparam int SQUELCH_CYC = SQUELCH_US * (CLK_HZ / 1_000_000);
  localparam int REG_PERIOD_CYC = REG_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int ADJ_REG_CYC = ADJ_REG_MS * (CLK_HZ / 1_000);

  typedef struct packed {
    logic clip_stage12;
    logic active_mode_gain_reduce;
  } rgm_cfg3_t;

  typedef struct packed {
    logic lowpass_select_hi;
    logic lowpass_select_lo;
    logic zero_setting_two;
    logic zero_setting_one;
    logic zero_setting_zero;
  } rgm_filt_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_MEAS_AMP,
    ST_SQUELCH,
    ST_ADJ_REG
  } rgm_state_t;

endpackage

/* tb/rgm_analog_model.sv */
/* rgm_analog_model: converter and supply monitor at the core's far side.
   assumes the core clock; levels are set by the bench. */
`timescale 1ns/1ps
module rgm_analog_model (
  input wire logic clk_i,
  input wire logic amp_det_en_i,
  input wire logic [3:0] reg_step_i,
  input wire logic [7:0] amp_level_i,
  input wire logic [3:0] ok_step_i,
  output logic adc_valid_o,
  output logic [7:0] adc_data_o,
  output logic margin_ok_o
);
  logic [3:0] cnt_reg = 4'h0;
  initial begin
    adc_valid_o = 1'b0;
    adc_data_o = 8'h00;
  end
  // result 9 cycles after enable, well inside 25 us
  always @(posedge clk_i) begin
    cnt_reg <= amp_det_en_i ? cnt_reg + 4'h1 : 4'h0;
    adc_valid_o <= amp_det_en_i && cnt_reg == 4'h8;
    // data undefined off the strobe, so it toggles
    adc_data_o <= (amp_det_en_i && cnt_reg == 4'h8) ? amp_level_i : ~adc_data_o;
  end
  // margin met once the step falls below the bench level
  assign margin_ok_o = reg_step_i < ok_step_i;
endmodule

/* tb/rgm_cmd_core_asserts.sv */
/* rgm_cmd_core_asserts: port checker for rgm_cmd_core.
   assumes the bind below and the core's single clock and reset. */
`timescale 1ns/1ps
module rgm_cmd_core_asserts import rgm_pkg::*; #(
  parameter int SQUELCH_CYCLES = 40,
  parameter int ADJ_REG_CYCLES = 400
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic mask_timer_run_i,
  input wire logic mask_timer_reset_o,
  input wire logic rx_on_o,
  input wire logic framing_en_o,
  input wire logic tx_force_on_o,
  input wire logic rx_force_on_o,
  input wire logic amp_det_en_o,
  input wire logic adc_abs_mode_o,
  input wire logic squelch_active_o,
  input wire logic agc_init_o,
  input wire logic [3:0] reg_step_o,
  input wire logic cmd_term_o,
  input wire logic busy_o
);
  localparam int SQ_LIM = SQUELCH_CYCLES + 2;
  localparam int ADJ_LIM = ADJ_REG_CYCLES + 2;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack missing");
  property p_ack1; ack_o |=> !ack_o; endproperty
  a_ack1: assert property (p_ack1) else $error("ack too long");
  property p_mask; !framing_en_o |-> !rx_on_o; endproperty
  a_mask: assert property (p_mask) else $error("gate open while masked");
  // an unmask taken while the timer runs opens the gate and resets the timer
  property p_timer;
    mask_timer_run_i |=> (!framing_en_o && !rx_on_o) || mask_timer_reset_o;
  endproperty
  a_timer: assert property (p_timer) else $error("timer mask ignored");
  property p_meas; amp_det_en_o |-> tx_force_on_o && adc_abs_mode_o && busy_o; endproperty
  a_meas: assert property (p_meas) else $error("measure path incomplete");
  property p_meas_len; $rose(amp_det_en_o) |-> ##[1:502] !amp_det_en_o; endproperty
  a_meas_len: assert property (p_meas_len) else $error("measure too long");
  property p_term; cmd_term_o |-> $past(tx_force_on_o); endproperty
  a_term: assert property (p_term) else $error("stray termination");
  property p_term1; cmd_term_o |=> !cmd_term_o; endproperty
  a_term1: assert property (p_term1) else $error("termination not a pulse");
  property p_sq_len; $rose(squelch_active_o) |-> ##[1:SQ_LIM] !squelch_active_o; endproperty
  a_sq_len: assert property (p_sq_len) else $error("squelch too long");
  property p_gain; agc_init_o |-> !squelch_active_o; endproperty
  a_gain: assert property (p_gain) else $error("squelch not aborted");
  property p_top; $rose(rx_force_on_o) && !amp_det_en_o |=> reg_step_o == 4'hA; endproperty
  a_top: assert property (p_top) else $error("regulator not at top");
  property p_step;
    $past(rx_force_on_o, 2) && rx_force_on_o && reg_step_o != $past(reg_step_o)
      |-> reg_step_o == $past(reg_step_o) - 4'h1;
  endproperty
  a_step: assert property (p_step) else $error("step not by one");
  property p_floor; reg_step_o <= 4'hA; endproperty
  a_floor: assert property (p_floor) else $error("step out of range");
  property p_adj_len; $rose(rx_force_on_o) |-> ##[1:ADJ_LIM] !rx_force_on_o; endproperty
  a_adj_len: assert property (p_adj_len) else $error("adjust too long");
  c_term: cover property (cmd_term_o);
  c_sq: cover property ($rose(squelch_active_o));
  c_agc: cover property (agc_init_o);
endmodule
bind rgm_cmd_core rgm_cmd_core_asserts #(.SQUELCH_CYCLES(SQUELCH_CYCLES),
  .ADJ_REG_CYCLES(ADJ_REG_CYCLES)) u_rgm_cmd_core_asserts (.clk_i, .rst_i, .cyc_i,
  .stb_i, .ack_o, .mask_timer_run_i, .mask_timer_reset_o, .rx_on_o, .framing_en_o,
  .tx_force_on_o,
  .rx_force_on_o, .amp_det_en_o, .adc_abs_mode_o, .squelch_active_o, .agc_init_o,
  .reg_step_o, .cmd_term_o, .busy_o);

/* tb/rgm_cmd_core_tb_top.sv */
/* rgm_cmd_core_tb_top: self-checking bench for rgm_cmd_core.
   assumes the analog model at the far side and shortened counts. */
`timescale 1ns/1ps
module rgm_cmd_core_tb_top import rgm_pkg::*;;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [7:0] adr_i = 8'h00, adc_data_i, manual_gain_o, amp_level = 8'h00;
  logic [3:0] sel_i = 4'hF, reg_step_o, ok_step = 4'hF;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic xtal_stable_i = 1'b0, mask_timer_run_i = 1'b0, adc_valid_i, margin_ok_i;
  logic ack_o, rx_on_o, framing_en_o, mask_timer_reset_o, tx_force_on_o, rx_force_on_o;
  logic amp_det_en_o, adc_abs_mode_o, squelch_active_o, agc_init_o, cmd_term_o, busy_o;
  rgm_cfg3_t cfg3_o;
  rgm_filt_t filt_o;
  int failures = 0, n_compared = 0, cycles = 0, n_term = 0, n_tmr = 0, n_agc = 0;
  always #25 clk_i = ~clk_i;
  rgm_cmd_core #(.SQUELCH_CYCLES(40), .REG_PERIOD_CYCLES(20), .ADJ_REG_CYCLES(400))
    u_rgm_cmd_core (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i,
    .dat_o, .ack_o, .xtal_stable_i, .margin_ok_i, .mask_timer_run_i, .adc_valid_i,
    .adc_data_i, .rx_on_o, .framing_en_o, .mask_timer_reset_o, .tx_force_on_o,
    .rx_force_on_o, .amp_det_en_o, .adc_abs_mode_o, .squelch_active_o, .agc_init_o,
    .manual_gain_o, .reg_step_o, .cmd_term_o, .busy_o, .cfg3_o, .filt_o);
  rgm_analog_model u_rgm_analog_model (.clk_i, .amp_det_en_i(amp_det_en_o),
    .reg_step_i(reg_step_o), .amp_level_i(amp_level), .ok_step_i(ok_step),
    .adc_valid_o(adc_valid_i), .adc_data_o(adc_data_i), .margin_ok_o(margin_ok_i));
  task automatic end_sim;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // pulses are counted here so no task can miss a one-cycle output
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cmd_term_o === 1'b1) n_term <= n_term + 1;
    if (mask_timer_reset_o === 1'b1) n_tmr <= n_tmr + 1;
    if (agc_init_o === 1'b1) n_agc <= n_agc + 1;
    if (cycles == 20000) begin
      failures++;
      end_sim();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] c);
    wb(1'b1, OFS_CMD, {24'h0, c});
  endtask
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask
  task automatic wterm(input int n);
    repeat (2000) begin
      if (n_term >= n) break;
      @(posedge clk_i);
    end
    chk("term count", 32'(n_term), 32'(n));
  endtask
  task automatic t_regs;
    wb(1'b1, OFS_RX_CFG3, 32'h3);
    rdchk("cfg3", OFS_RX_CFG3, 32'h3);
    chk("cfg3_o", {30'h0, cfg3_o}, 32'h3);
    wb(1'b1, OFS_RX_FILT, 32'h1A);
    rdchk("filter", OFS_RX_FILT, 32'h1A);
    chk("filt_o", {27'h0, filt_o}, 32'h1A);
    rdchk("unmapped", 8'h1C, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_mask;
    cmd(CMD_MASK_RX);
    rdchk("mask no rx_en", OFS_STATUS, 32'hA0);
    wb(1'b1, OFS_CTRL, 32'h40);
    cmd(CMD_MASK_RX);
    rdchk("masked", OFS_STATUS, 32'hA4);
    chk("framing", {31'h0, framing_en_o}, 32'h0);
    cmd(CMD_UNMASK_RX);
    rdchk("unmasked", OFS_STATUS, 32'hA2);
    mask_timer_run_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk("timer gate", {30'h0, rx_on_o, framing_en_o}, 32'h0);
    cmd(CMD_UNMASK_RX);
    repeat (2) @(posedge clk_i);
    chk("timer reset", 32'(n_tmr), 32'h1);
    mask_timer_run_i <= 1'b0;
    $display("t_mask done");
  endtask
  task automatic t_meas;
    wb(1'b1, OFS_CTRL, 32'h80);
    cmd(CMD_MEAS_AMP);
    rdchk("no xtal", OFS_STATUS, 32'hA0);
    xtal_stable_i <= 1'b1;
    amp_level <= 8'hF0;
    // crystal level needs its two sync flops before the command
    repeat (3) @(posedge clk_i);
    cmd(CMD_MEAS_AMP);
    chk("meas path", {29'h0, tx_force_on_o, amp_det_en_o, adc_abs_mode_o}, 32'h7);
    cmd(CMD_ADJ_REG);
    wterm(1);
    repeat (100) @(posedge clk_i);
    chk("no chain", 32'(n_term), 32'h1);
    rdchk("saturated", OFS_ADC_OUT, {24'h0, AMP_MAX_CODE});
    amp_level <= 8'h55;
    cmd(CMD_MEAS_AMP);
    wterm(2);
    rdchk("amplitude", OFS_ADC_OUT, 32'h55);
    $display("t_meas done");
  endtask
  task automatic t_squelch;
    wb(1'b1, OFS_CTRL, 32'hC8);
    cmd(CMD_SQUELCH);
    rdchk("squelch gate high", OFS_STATUS, 32'hA2);
    cmd(CMD_MASK_RX);
    cmd(CMD_SQUELCH);
    rdchk("squelch on", OFS_STATUS, 32'hAD);
    wb(1'b1, OFS_RX_CFG4, 32'h5A);
    cmd(CMD_RESET_GAIN);
    rdchk("squelch aborted", OFS_STATUS, 32'hA4);
    chk("manual gain", {24'h0, manual_gain_o}, 32'h5A);
    chk("gain init", 32'(n_agc), 32'h1);
    cmd(CMD_SQUELCH);
    repeat (60) @(posedge clk_i);
    rdchk("squelch end", OFS_STATUS, 32'hA4);
    chk("no squelch term", 32'(n_term), 32'h2);
    $display("t_squelch done");
  endtask
  task automatic t_adj;
    wb(1'b1, OFS_CTRL, 32'h84);
    cmd(CMD_ADJ_REG);
    repeat (5) @(posedge clk_i);
    chk("ext refused", {31'h0, rx_force_on_o}, 32'h0);
    wb(1'b1, OFS_CTRL, 32'h81);
    ok_step <= 4'h8;
    cmd(CMD_ADJ_REG);
    wterm(3);
    repeat (2) @(posedge clk_i);
    chk("step margin", {28'h0, reg_step_o}, 32'h7);
    ok_step <= 4'h0;
    cmd(CMD_ADJ_REG);
    wterm(4);
    repeat (2) @(posedge clk_i);
    chk("step floor", {28'h0, reg_step_o}, 32'h0);
    $display("t_adj done");
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_regs();
    t_mask();
    t_meas();
    t_squelch();
    t_adj();
    end_sim();
  end
endmodule
